// File: rtl/arm_crc16.sv
// Bytewise CRC-16 register, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module arm_crc16
   import arm_pkg::*;
#(
   parameter logic [15:0] POLY = CRC_POLY,
   parameter logic [15:0] INIT = CRC_INIT
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic enable,
   input wire logic [7:0] data_byte,
   // Remainder
   output logic [15:0] crc_out
);
   // ==========================================================
   // One byte step
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] din);
      logic [15:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--)
      begin
         c = (c[15] ^ din[i]) ? ((c << 1) ^ POLY) : (c << 1);
      end
      return c;
   endfunction : crc_step

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear)
      begin
         crc_out <= INIT;
      end
      else if (enable)
      begin
         crc_out <= crc_step(crc_out, data_byte);
      end
   end
endmodule : arm_crc16
`default_nettype wire

// File: rtl/arm_monitor.sv
// Converter control, result formatting and output integrity top
// Functional notes
// - Burn-out bit drives source and sink currents
// - Monitor selection bypasses amplifier, gain one
// - Code 1101 measures supply quarter, internal reference
// - Code 1100 measures reference quarter, internal reference
// - Temperature mode ignores register zero, internal reference
// - Temperature result left-justified in 24 bits
// - Count is 0.03125 degC, two's complement
// - Temperature codes follow published examples
// - Counter byte precedes result when enabled
// - Counter resets zero, counts conversions, wraps
// - Counter clears on re-enable and reset
// - Integrity covers register, result and counter
// - Mode 01 appends inverted data copy
// - Mode 10 appends 16-bit checksum
// - CCITT polynomial, preset FFFF, data only
// - Shorted-input setting for offset measurement
// - Any reset aborts activity at once
// - Sleep command waits for running conversion
// - Mode bit picks single or continuous
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module arm_monitor
   import arm_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Modulator interface
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [RESULT_BITS-1:0] conv_result,
   input wire logic [TEMP_BITS-1:0] temp_code,
   output logic powered_down,
   // Analog front-end controls
   output arm_analog_t analog_ctrl,
   // Output byte stream request
   input wire arm_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   // Output byte stream
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready
);
   // ==========================================================
   // Declarations
   arm_cfg_t cfg_reg;
   arm_cfg_t cfg_next;
   arm_conv_state_t cs_reg;
   arm_tx_state_t tx_state_reg;
   logic soft_rst_reg;
   logic core_rst;
   logic [ADDR_W-1:0] awaddr_reg;
   logic aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic w_held_reg;
   logic wr_fire;
   logic wr_hit;
   logic start_cmd;
   logic sleep_cmd;
   logic sleep_pend_reg;
   logic cnt_en_prev_reg;
   logic [7:0] count_reg;
   logic [RESULT_BITS-1:0] result_reg;
   logic ready_flag_reg;
   logic result_read;
   logic rd_fire;
   logic [31:0] rd_word;
   logic rd_ok;
   logic [31:0] frame_reg;
   logic [1:0] last_idx_reg;
   logic [1:0] idx_reg;
   logic [1:0] mode_reg;
   logic [7:0] cur_byte;
   logic tx_fire;
   logic req_take;
   logic [15:0] crc_val;
   logic monitor_sel;

   assign core_rst = !aresetn || soft_rst_reg;

   // ==========================================================
   // AXI4-Lite write channel
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit = (awaddr_reg == ADDR_CONFIG) || (awaddr_reg == ADDR_COMMAND);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Commands take effect only when their byte lane is written
   assign start_cmd = wr_fire && (awaddr_reg == ADDR_COMMAND) && wstrb_reg[0]
      && wdata_reg[CMD_START_BIT];
   assign sleep_cmd = wr_fire && (awaddr_reg == ADDR_COMMAND) && wstrb_reg[0]
      && wdata_reg[CMD_SLEEP_BIT];

   // ==========================================================
   // Configuration register and soft reset
   always_comb
   begin
      cfg_next = cfg_reg;
      if (wr_fire && (awaddr_reg == ADDR_CONFIG))
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wstrb_reg[b])
            begin
               cfg_next[8*b +: 8] = wdata_reg[8*b +: 8];
            end
         end
         cfg_next.reserved = '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         cfg_reg <= CONFIG_RESET;
      end
      else
      begin
         cfg_reg <= cfg_next;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         soft_rst_reg <= 1'b0;
      end
      else
      begin
         soft_rst_reg <= wr_fire && (awaddr_reg == ADDR_COMMAND) && wstrb_reg[0]
            && wdata_reg[CMD_RESET_BIT];
      end
   end

   // ==========================================================
   // Analog controls
   assign monitor_sel = (cfg_reg.input_select == INPUT_SEL_REF_MON)
      || (cfg_reg.input_select == INPUT_SEL_SUPPLY_MON);

   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         analog_ctrl <= '0;
      end
      else
      begin
         analog_ctrl.burnout_source <= cfg_reg.burnout_source_enable;
         analog_ctrl.burnout_sink <= cfg_reg.burnout_source_enable;
         analog_ctrl.temp_select <= cfg_reg.temp_sensor_enable;
         analog_ctrl.ref_select <= cfg_reg.ref_select;
         // Shorted-input code passes through unchanged
         analog_ctrl.input_select <= cfg_reg.temp_sensor_enable ? 4'h0
            : cfg_reg.input_select;
         analog_ctrl.pga_bypass <= monitor_sel && !cfg_reg.temp_sensor_enable;
         analog_ctrl.gain <= (monitor_sel || cfg_reg.temp_sensor_enable) ? GAIN_ONE
            : cfg_reg.gain;
         analog_ctrl.internal_ref <= monitor_sel || cfg_reg.temp_sensor_enable;
         analog_ctrl.monitor_div4 <= monitor_sel && !cfg_reg.temp_sensor_enable;
      end
   end

   // ==========================================================
   // Conversion sequencing
   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         cs_reg <= CS_IDLE;
         conv_start <= 1'b0;
         powered_down <= 1'b0;
         sleep_pend_reg <= 1'b0;
      end
      else
      begin
         conv_start <= 1'b0;
         unique case (cs_reg)
            CS_IDLE, CS_SLEEP:
            begin
               if (start_cmd)
               begin
                  cs_reg <= CS_BUSY;
                  conv_start <= 1'b1;
                  powered_down <= 1'b0;
               end
               else if (sleep_cmd)
               begin
                  cs_reg <= CS_SLEEP;
                  powered_down <= 1'b1;
               end
            end
            CS_BUSY:
            begin
               if (start_cmd)
               begin
                  conv_start <= 1'b1;
                  sleep_pend_reg <= 1'b0;
               end
               else if (sleep_cmd)
               begin
                  sleep_pend_reg <= 1'b1;
               end
               if (conv_done && !start_cmd)
               begin
                  if (sleep_pend_reg || sleep_cmd)
                  begin
                     cs_reg <= CS_SLEEP;
                     powered_down <= 1'b1;
                     sleep_pend_reg <= 1'b0;
                  end
                  else if (cfg_reg.conversion_mode_select)
                  begin
                     conv_start <= 1'b1;
                  end
                  else
                  begin
                     cs_reg <= CS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Result capture, counter and ready flag
   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         result_reg <= '0;
         count_reg <= COUNT_RESET;
         cnt_en_prev_reg <= 1'b0;
         ready_flag_reg <= 1'b0;
      end
      else
      begin
         cnt_en_prev_reg <= cfg_reg.conversion_counter_enable;
         if (conv_done && cs_reg == CS_BUSY)
         begin
            // Temperature count is already two's complement
            result_reg <= cfg_reg.temp_sensor_enable
               ? {temp_code, {TEMP_PAD_BITS{1'b0}}} : conv_result;
         end
         if (cfg_reg.conversion_counter_enable && !cnt_en_prev_reg)
         begin
            count_reg <= (conv_done && cs_reg == CS_BUSY) ? 8'h01 : COUNT_RESET;
         end
         else if (conv_done && cs_reg == CS_BUSY)
         begin
            count_reg <= count_reg + 8'h01;
         end
         if (conv_done && cs_reg == CS_BUSY)
         begin
            ready_flag_reg <= 1'b1;
         end
         else if (result_read)
         begin
            ready_flag_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign result_read = (rd_fire && s_axi_araddr == ADDR_RESULT)
      || (req_take && !req.is_register);

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ADDR_CONFIG: rd_word = cfg_reg;
         ADDR_COMMAND: rd_word = 32'h0000_0000;
         ADDR_STATUS: rd_word = {19'h00000, count_reg, ready_flag_reg,
            sleep_pend_reg, powered_down, cs_reg == CS_BUSY, tx_state_reg != TX_IDLE};
         ADDR_RESULT: rd_word = {8'h00, result_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Output byte stream
   assign req_take = req_valid && req_ready;
   assign tx_fire = tx_valid && tx_ready;

   always_comb
   begin
      cur_byte = frame_reg[8*(3-idx_reg) +: 8];
      if (tx_state_reg == TX_INV)
      begin
         cur_byte = ~frame_reg[8*(3-idx_reg) +: 8];
      end
      else if (tx_state_reg == TX_CRC)
      begin
         cur_byte = idx_reg[0] ? crc_val[7:0] : crc_val[15:8];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         tx_state_reg <= TX_IDLE;
         req_ready <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         frame_reg <= 32'h0000_0000;
         last_idx_reg <= 2'h0;
         idx_reg <= 2'h0;
         mode_reg <= INTEG_NONE;
      end
      else
      begin
         req_ready <= (tx_state_reg == TX_IDLE) && !req_take;
         unique case (tx_state_reg)
            TX_IDLE:
            begin
               if (req_take)
               begin
                  tx_state_reg <= TX_DATA;
                  idx_reg <= 2'h0;
                  mode_reg <= cfg_reg.integrity_mode;
                  if (req.is_register)
                  begin
                     frame_reg <= {cfg_reg[8*req.reg_byte +: 8], 24'h000000};
                     last_idx_reg <= 2'h0;
                  end
                  else if (cfg_reg.conversion_counter_enable)
                  begin
                     frame_reg <= {count_reg, result_reg};
                     last_idx_reg <= 2'h3;
                  end
                  else
                  begin
                     frame_reg <= {result_reg, 8'h00};
                     last_idx_reg <= 2'h2;
                  end
               end
            end
            TX_DATA, TX_INV, TX_CRC:
            begin
               if (!tx_valid)
               begin
                  tx_valid <= 1'b1;
                  tx_data <= cur_byte;
               end
               else if (tx_fire)
               begin
                  tx_valid <= 1'b0;
                  idx_reg <= idx_reg + 2'h1;
                  if (tx_state_reg == TX_CRC ? idx_reg[0] : idx_reg == last_idx_reg)
                  begin
                     idx_reg <= 2'h0;
                     tx_state_reg <= TX_IDLE;
                     if (tx_state_reg == TX_DATA && mode_reg == INTEG_INVERT)
                     begin
                        tx_state_reg <= TX_INV;
                     end
                     else if (tx_state_reg == TX_DATA && mode_reg == INTEG_CRC)
                     begin
                        tx_state_reg <= TX_CRC;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Checksum over data bytes only, in send order
   arm_crc16 #(
      .POLY(CRC_POLY),
      .INIT(CRC_INIT)
   ) u_crc (
      .aclk(aclk),
      .aresetn(!core_rst),
      .clear(req_take),
      .enable(tx_fire && tx_state_reg == TX_DATA),
      .data_byte(tx_data),
      .crc_out(crc_val)
   );
endmodule : arm_monitor
`default_nettype wire

// File: rtl/arm_pkg.sv
// Shared constants and types of the converter result integrity monitor
package arm_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_COMMAND = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_RESULT = 4'hC;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_SLEEP_BIT = 1;
   localparam int CMD_RESET_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Input selection and analog codes
   localparam logic [3:0] INPUT_SEL_REF_MON = 4'hC;
   localparam logic [3:0] INPUT_SEL_SUPPLY_MON = 4'hD;
   localparam logic [3:0] INPUT_SEL_SHORTED = 4'hE;
   localparam logic [2:0] GAIN_ONE = 3'h0;
   localparam int BURNOUT_CURRENT_UA = 10;
   // ==========================================================
   // Integrity modes and checksum
   localparam logic [1:0] INTEG_NONE = 2'h0;
   localparam logic [1:0] INTEG_INVERT = 2'h1;
   localparam logic [1:0] INTEG_CRC = 2'h2;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   // ==========================================================
   // Result formatting
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam int RESULT_BITS = 24;
   localparam int TEMP_BITS = 14;
   localparam int TEMP_PAD_BITS = RESULT_BITS - TEMP_BITS;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [16:0] reserved;
      logic [1:0] integrity_mode;
      logic conversion_mode_select;
      logic conversion_counter_enable;
      logic temp_sensor_enable;
      logic [1:0] ref_select;
      logic burnout_source_enable;
      logic [2:0] gain;
      logic [3:0] input_select;
   } arm_cfg_t;

   typedef struct packed {
      logic burnout_source;
      logic burnout_sink;
      logic pga_bypass;
      logic [2:0] gain;
      logic internal_ref;
      logic [1:0] ref_select;
      logic [3:0] input_select;
      logic temp_select;
      logic monitor_div4;
   } arm_analog_t;

   typedef struct packed {
      logic is_register;
      logic [1:0] reg_byte;
   } arm_req_t;

   typedef enum logic [1:0] {CS_IDLE, CS_BUSY, CS_SLEEP} arm_conv_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_INV, TX_CRC} arm_tx_state_t;
endpackage : arm_pkg

// File: verif/arm_host_model.sv
// Host side byte sink with stalls
`timescale 1ns/1ps
`default_nettype none
module arm_host_model
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pacing
   input wire logic slow,
   // Byte stream
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] rx_q[$];
   logic [1:0] cnt_reg = 2'h0;
   // ====
   // Pacing and capture
   assign tx_ready = !slow || cnt_reg == 2'h3;
   always @(posedge aclk)
   begin
      cnt_reg <= aresetn ? cnt_reg + 2'h1 : 2'h0;
      if (aresetn && tx_valid && tx_ready)
         rx_q.push_back(tx_data);
   end
endmodule : arm_host_model
`default_nettype wire

// File: verif/arm_monitor_props.sv
// Port checks of the result integrity monitor
`timescale 1ns/1ps
`default_nettype none
module arm_monitor_props
   import arm_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Converter
   input wire logic conv_start,
   input wire logic powered_down,
   input wire arm_analog_t analog_ctrl,
   // Stream
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   // ====
   // Sequences
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wire logic sel_sup = analog_ctrl.input_select == INPUT_SEL_SUPPLY_MON;
   wire logic sel_ref = analog_ctrl.input_select == INPUT_SEL_REF_MON;
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_first;
      !req_ready && !tx_valid ##1 tx_valid;
   endsequence
   // ====
   // Checks
   AST_BURNOUT: assert property (analog_ctrl.burnout_source == analog_ctrl.burnout_sink)
      else $error("Burn-out source and sink differ");
   AST_MON_GAIN: assert property (sel_sup || sel_ref |-> analog_ctrl.pga_bypass
      && analog_ctrl.gain == GAIN_ONE) else $error("Monitor input not at gain one");
   AST_SUP_REF: assert property (sel_sup |-> analog_ctrl.internal_ref)
      else $error("Supply monitor without internal reference");
   AST_REF_MON: assert property (sel_ref |-> analog_ctrl.internal_ref)
      else $error("Reference monitor without internal reference");
   AST_TEMP: assert property (analog_ctrl.temp_select |-> analog_ctrl.internal_ref
      && analog_ctrl.gain == GAIN_ONE) else $error("Temperature mode settings wrong");
   AST_FRAME: assert property (s_take |=> s_first)
      else $error("Stream start timing wrong");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("Stream byte not held");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("Read data not held");
   AST_RESET: assert property (disable iff (1'h0) !aresetn
      |=> !conv_start && !tx_valid && !powered_down && !req_ready)
      else $error("Outputs active after reset");
endmodule : arm_monitor_props
bind arm_monitor arm_monitor_props i_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .conv_start, .powered_down, .analog_ctrl,
   .req_valid, .req_ready, .tx_data, .tx_valid, .tx_ready);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the result integrity monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import arm_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start, powered_down;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic conv_done = 1'h0, pend = 1'h0, req_valid = 1'h0, slow = 1'h0;
   logic req_ready, tx_valid, tx_ready;
   logic [23:0] conv_result = 24'h5A1234;
   logic [13:0] temp_code = 14'h0;
   logic [7:0] tx_data;
   logic [3:0] m[3] = '{4'hC, 4'hD, 4'hE};
   logic [9:0] mx[3] = '{10'h38C, 10'h38D, 10'h05E};
   logic [13:0] t[2] = '{14'h0FFF, 14'h3B00};
   arm_analog_t analog_ctrl;
   arm_req_t req = '0;
   int error_cnt = 0, checks_done = 0, done_cnt = 0, done_max = 0;
   always #12.5 aclk = ~aclk;
   arm_monitor i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_done, .conv_result,
      .temp_code, .powered_down, .analog_ctrl, .req, .req_valid, .req_ready, .tx_data,
      .tx_valid, .tx_ready);
   arm_host_model i_host (.aclk, .aresetn, .slow, .tx_data, .tx_valid, .tx_ready);
   // ====
   // Modulator stand-in
   always @(posedge aclk)
   begin
      conv_done <= (pend || conv_start === 1'h1) && done_cnt < done_max;
      pend <= (pend || conv_start === 1'h1) && done_cnt >= done_max;
      if ((pend || conv_start === 1'h1) && done_cnt < done_max)
         done_cnt <= done_cnt + 1;
   end
   // ====
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (s_axi_bvalid !== 1'h1)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end
      chk(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] x);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (s_axi_rvalid !== 1'h1)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end
      chk(s_axi_rdata & msk, x);
      chk(32'(s_axi_rresp), 32'(RESP_OKAY));
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic run(input int n, input logic go);
      @(negedge aclk);
      done_max = done_cnt + n;
      if (go) wr(ADDR_COMMAND, 32'h1, RESP_OKAY);
      for (int i = 0; i < 5000 && done_cnt != done_max; i++) @(posedge aclk);
      repeat (3) @(posedge aclk);
   endtask : run
   task automatic frame(input logic isreg, input logic [1:0] b, input logic [7:0] e[$]);
      @(posedge aclk);
      req <= '{is_register: isreg, reg_byte: b};
      req_valid <= 1'h1;
      for (int i = 0; i < 20; i++)
      begin
         @(posedge aclk);
         if (req_ready === 1'h1) break;
      end
      req_valid <= 1'h0;
      for (int i = 0; i < 500 && i_host.rx_q.size() < e.size(); i++) @(posedge aclk);
      foreach (e[i]) chk(32'(i_host.rx_q.pop_front()), 32'(e[i]));
   endtask : frame
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
         for (int j = 7; j >= 0; j--)
            c = {c[14:0], 1'h0} ^ ((c[15] ^ q[i][j]) ? 16'h1021 : 16'h0);
      return c;
   endfunction : crc
   // ====
   // Tests
   initial
   begin
      #300000;
      error_cnt++;
      test_done();
   end
   initial
   begin
      logic [7:0] e[$];
      logic [23:0] r;
      logic [15:0] c;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ADDR_CONFIG, 32'hFFFFFFFF, CONFIG_RESET);
      rd(ADDR_COMMAND, 32'hFFFFFFFF, 32'h0);
      wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
      wr(ADDR_CONFIG, 32'hFFFFFFFF, RESP_OKAY);
      rd(ADDR_CONFIG, 32'hFFFFFFFF, 32'h7FFF);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_CONFIG, {24'h0, 4'h5, m[i]}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk(32'({analog_ctrl.monitor_div4, analog_ctrl.internal_ref, analog_ctrl.pga_bypass,
            analog_ctrl.gain, analog_ctrl.input_select}), 32'(mx[i]));
      end
      wr(ADDR_CONFIG, 32'h23D5, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'({analog_ctrl.ref_select, analog_ctrl.burnout_source,
         analog_ctrl.burnout_sink}), 32'hF);
      e = {8'h23, 8'hDC};
      frame(1'h1, 2'h1, e);
      wr(ADDR_COMMAND, 32'h4, RESP_OKAY);
      rd(ADDR_CONFIG, 32'hFFFFFFFF, CONFIG_RESET);
      wr(ADDR_CONFIG, 32'h4C00, RESP_OKAY);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge aclk);
         temp_code <= t[i];
         run(1, 1'h1);
         chk(32'(analog_ctrl.temp_select), 32'h1);
         rd(ADDR_RESULT, 32'hFFFFFF, {8'h0, t[i], 10'h0});
      end
      r = {t[1], 10'h0};
      e = {8'h02, r[23:16], r[15:8], r[7:0]};
      c = crc(e);
      e.push_back(c[15:8]);
      e.push_back(c[7:0]);
      slow <= 1'h1;
      frame(1'h0, 2'h0, e);
      slow <= 1'h0;
      wr(ADDR_CONFIG, 32'h1800, RESP_OKAY);
      run(254, 1'h1);
      rd(ADDR_STATUS, 32'h1FE0, 32'h0);
      rd(ADDR_RESULT, 32'hFFFFFF, 32'h5A1234);
      wr(ADDR_COMMAND, 32'h2, RESP_OKAY);
      rd(ADDR_STATUS, 32'hC, 32'h8);
      run(1, 1'h0);
      rd(ADDR_STATUS, 32'h1FEC, 32'h24);
      wr(ADDR_CONFIG, 32'h1000, RESP_OKAY);
      wr(ADDR_CONFIG, 32'h1800, RESP_OKAY);
      rd(ADDR_STATUS, 32'h1FE0, 32'h0);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
